// File: design/asr_pkg.sv
package asr_pkg;
  // Device geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  // Clock period in ps
  localparam int CLK_PS = 20000;
  // Timing figures
  localparam int T_POWER_US = 100;
  localparam int T_RC_NS    = 10;
  localparam int T_AA_NS    = 10;
  localparam int T_WC_NS    = 10;
  localparam int T_PWE_NS   = 7;
  localparam int T_SD_NS    = 6;
  localparam int T_DOE_NS   = 5;
  localparam int T_HZ_NS    = 5;
  // Least times round up, at least one cycle
  function automatic int cyc_min(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int POWER_CYC = cyc_min(T_POWER_US * 1000 * 1000);
  localparam int RC_CYC    = cyc_min(T_RC_NS * 1000);
  localparam int AA_CYC    = cyc_min(T_AA_NS * 1000);
  localparam int WC_CYC    = cyc_min(T_WC_NS * 1000);
  localparam int PWE_CYC   = cyc_min(T_PWE_NS * 1000);
  localparam int SD_CYC    = cyc_min(T_SD_NS * 1000);
  localparam int DOE_CYC   = cyc_min(T_DOE_NS * 1000);
  localparam int HZ_CYC    = cyc_min(T_HZ_NS * 1000);
  localparam int CNT_W     = 18;
  // Controller states
  typedef enum logic [2:0] {
    ASR_POWER,
    ASR_IDLE,
    ASR_RD_SETUP,
    ASR_RD_WAIT,
    ASR_WR_PULSE,
    ASR_WR_END,
    ASR_RETAIN,
    ASR_RECOVER
  } asr_state_t;
endpackage

// File: design/asr_host.sv
`timescale 1ns/1ps
// Overview of operation
// - Data timed from the edge ending write
// - Wait 100 us before first access
// - Deselect before retention; recover two cycles
// - Reads spaced 10 ns; data by 10 ns
// - Writes 10 ns, address and strobe 7 ns
// - Address valid at write start, zero hold
// - Select and bytes low 7 ns before end
// - Write data 6 ns setup, zero hold
// - Write strobe high during every read
// - Address before or with chip select fall
module asr_host #(
  parameter int POWER_WAIT = asr_pkg::POWER_CYC
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // User request
  input  wire logic                        req_i,
  input  wire logic                        we_i,
  input  wire logic [asr_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [asr_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic [1:0]                  be_i,
  input  wire logic                        retain_i,
  output logic                             ready_o,
  output logic                             done_o,
  output logic [asr_pkg::DATA_W-1:0]       rdata_o,
  // Memory pins
  output logic [asr_pkg::ADDR_W-1:0]       mem_addr_o,
  output logic                             chip_select_n_o,
  output logic                             output_enable_n_o,
  output logic                             write_strobe_n_o,
  output logic                             low_byte_select_n_o,
  output logic                             high_byte_select_n_o,
  input  wire logic [asr_pkg::DATA_W-1:0]  data_lines_i,
  output logic [asr_pkg::DATA_W-1:0]       data_lines_o,
  output logic [asr_pkg::DATA_W-1:0]       data_lines_oe_o
);
  import asr_pkg::*;

  if (POWER_WAIT < 1 || POWER_WAIT >= (1 << CNT_W))
  begin : g_power_wait_check
    $error("POWER_WAIT out of range");
  end

  logic       rst_s1_q;
  logic       rst_n_q;
  asr_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
  logic [DATA_W-1:0] oe_q, oe_d;
  logic       cs_q, cs_d, oen_q, oen_d, wen_q, wen_d, bl_q, bl_d, bh_q, bh_d;
  logic       rdy_q, rdy_d, done_q, done_d;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    rd_d   = rd_q;
    oe_d   = oe_q;
    cs_d   = cs_q;
    oen_d  = oen_q;
    wen_d  = wen_q;
    bl_d   = bl_q;
    bh_d   = bh_q;
    rdy_d  = 1'b0;
    done_d = 1'b0;
    case (st_q)
      ASR_POWER:
      begin
        if (cnt_q == CNT_W'(POWER_WAIT - 1))
        begin
          st_d  = ASR_IDLE;
          rdy_d = 1'b1;
        end
        else
          cnt_d = cnt_q + 1'b1;
      end
      ASR_IDLE:
      begin
        rdy_d = 1'b1;
        cnt_d = '0;
        if (retain_i)
        begin
          st_d  = ASR_RETAIN;
          cs_d  = 1'b1;
          rdy_d = 1'b0;
        end
        else if (req_i && be_i != 2'b00)
        begin
          rdy_d  = 1'b0;
          addr_d = addr_i;
          wd_d   = wdata_i;
          bl_d   = ~be_i[0];
          bh_d   = ~be_i[1];
          if (we_i)
            st_d = ASR_WR_PULSE;
          else
            st_d = ASR_RD_SETUP;
        end
      end
      ASR_RD_SETUP:
      begin
        cs_d  = 1'b0;
        oen_d = 1'b0;
        wen_d = 1'b1;
        st_d  = ASR_RD_WAIT;
      end
      ASR_RD_WAIT:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(AA_CYC))
        begin
          rd_d   = data_lines_i;
          cs_d   = 1'b1;
          oen_d  = 1'b1;
          bl_d   = 1'b1;
          bh_d   = 1'b1;
          done_d = 1'b1;
          st_d   = ASR_IDLE;
        end
      end
      ASR_WR_PULSE:
      begin
        cs_d  = 1'b0;
        wen_d = 1'b0;
        oe_d  = {{LANE_W{~bh_q}}, {LANE_W{~bl_q}}};
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(PWE_CYC))
        begin
          wen_d = 1'b1;
          cs_d  = 1'b1;
          st_d  = ASR_WR_END;
        end
      end
      ASR_WR_END:
      begin
        oe_d   = '0;
        bl_d   = 1'b1;
        bh_d   = 1'b1;
        done_d = 1'b1;
        st_d   = ASR_IDLE;
      end
      ASR_RETAIN:
      begin
        cnt_d = '0;
        if (!retain_i)
          st_d = ASR_RECOVER;
      end
      ASR_RECOVER:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(RC_CYC))
        begin
          st_d  = ASR_IDLE;
          rdy_d = 1'b1;
        end
      end
      default:
        st_d = ASR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q   <= ASR_POWER;
      cnt_q  <= '0;
      addr_q <= '0;
      wd_q   <= '0;
      rd_q   <= '0;
      oe_q   <= '0;
      cs_q   <= 1'b1;
      oen_q  <= 1'b1;
      wen_q  <= 1'b1;
      bl_q   <= 1'b1;
      bh_q   <= 1'b1;
      rdy_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
      oe_q   <= oe_d;
      cs_q   <= cs_d;
      oen_q  <= oen_d;
      wen_q  <= wen_d;
      bl_q   <= bl_d;
      bh_q   <= bh_d;
      rdy_q  <= rdy_d;
      done_q <= done_d;
    end
  end

  assign ready_o              = rdy_q;
  assign done_o               = done_q;
  assign rdata_o              = rd_q;
  assign mem_addr_o           = addr_q;
  assign chip_select_n_o      = cs_q;
  assign output_enable_n_o    = oen_q;
  assign write_strobe_n_o     = wen_q;
  assign low_byte_select_n_o  = bl_q;
  assign high_byte_select_n_o = bh_q;
  assign data_lines_o         = wd_q;
  assign data_lines_oe_o      = oe_q;
endmodule

// File: test/asr_host_properties.sv
`timescale 1ns/1ps
module asr_host_properties #(
  parameter int POWER_WAIT = 4
) (
  // Watched pins
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        done_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        chip_select_n_o,
  input wire logic        output_enable_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic        low_byte_select_n_o,
  input wire logic        high_byte_select_n_o,
  input wire logic [15:0] data_lines_o,
  input wire logic [15:0] data_lines_oe_o
);
  logic [17:0] up_q;
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) up_q <= '0;
    else if (up_q < 18'h3_ffff) up_q <= up_q + 1'b1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_POWER_WAIT: assert property (!chip_select_n_o |-> up_q >= POWER_WAIT)
    else $error("select before power wait");
  AST_READ_STROBE: assert property (!output_enable_n_o |-> write_strobe_n_o)
    else $error("strobe low in read");
  AST_END_TOGETHER: assert property ($rose(write_strobe_n_o) |-> $rose(chip_select_n_o))
    else $error("write end split");
  AST_ADDR_SETUP: assert property ($fell(chip_select_n_o) |-> $stable(mem_addr_o))
    else $error("address moves at select");
  AST_WR_HOLD: assert property (!write_strobe_n_o |->
    $stable(mem_addr_o) && $stable(data_lines_o))
    else $error("address or data moves in write");
  AST_WR_WIDTH: assert property ($fell(write_strobe_n_o) |->
    (!chip_select_n_o && !(low_byte_select_n_o && high_byte_select_n_o))
    ##1 (write_strobe_n_o && chip_select_n_o && !(low_byte_select_n_o && high_byte_select_n_o)))
    else $error("write pulse short");
  AST_RD_TIME: assert property ($fell(output_enable_n_o) |->
    !chip_select_n_o[*2] ##1 done_o)
    else $error("read cycle length");
  AST_NO_FIGHT: assert property (!output_enable_n_o |-> data_lines_oe_o == 16'h0000)
    else $error("host drives during read");
  cover property ($fell(write_strobe_n_o));
  cover property ($fell(output_enable_n_o));
  cover property (done_o);
endmodule
bind asr_host asr_host_properties #(.POWER_WAIT(POWER_WAIT)) u_chk (.clk_i, .reset_n_i, .done_o,
  .mem_addr_o, .chip_select_n_o, .output_enable_n_o, .write_strobe_n_o, .low_byte_select_n_o,
  .high_byte_select_n_o, .data_lines_o, .data_lines_oe_o);

// File: test/asr_sram_model.sv
`timescale 1ns/1ps
module asr_sram_model #(
  parameter int DLY  = 5,
  parameter int HOLD = 3
) (
  // Memory pins
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  bs_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] host_d_i,
  input  wire logic [15:0] host_oe_i,
  output logic      [15:0] dq_o
);
  logic [15:0] mem [0:65535];
  logic [1:0]  lane_on;
  logic [15:0] dev_en;
  logic        rd;
  logic [15:0] rd_addr;
  logic [15:0] wr_bus;
  assign rd = !cs_n_i && !oe_n_i && we_n_i;
  // Old word stays a while after the address moves
  assign #(HOLD) rd_addr = addr_i;
  // Lanes the host leaves floating write zeros
  assign wr_bus = host_d_i & host_oe_i;
  assign #(DLY) lane_on = {2{rd}} & ~bs_n_i;
  assign dev_en = {{8{lane_on[1]}}, {8{lane_on[0]}}};
  // Floating lanes show the inverse word
  assign dq_o = (host_oe_i & host_d_i) | (~host_oe_i & (mem[rd_addr] ^ ~dev_en));
  always @*
    if (!cs_n_i && !we_n_i)
    begin
      if (!bs_n_i[0]) mem[addr_i][7:0] = wr_bus[7:0];
      if (!bs_n_i[1]) mem[addr_i][15:8] = wr_bus[15:8];
    end
endmodule

// File: test/asr_host_tb.sv
`timescale 1ns/1ps
module asr_host_tb;
  import asr_pkg::*;
  typedef struct {logic w; logic [15:0] a, d; logic [1:0] b; logic [15:0] e;} asr_row_t;
  logic        clk_i = 0, reset_n_i = 0, req_i = 0, we_i = 0, retain_i = 0;
  logic [15:0] addr_i = 0, wdata_i = 0, rdata_o, ma, dlo, doe, dli;
  logic [1:0]  be_i = 0;
  logic        ready_o, done_o, cs, oe, we, lb, hb;
  int          fails = 0, n_checks = 0;
  asr_row_t    rows [8] = '{'{1, 16'h0001, 16'ha5c3, 2'h3, 0}, '{1, 16'hffff, 16'h1234, 2'h3, 0},
    '{1, 16'h0001, 16'h00ff, 2'h1, 0}, '{1, 16'hffff, 16'hab00, 2'h2, 0},
    '{0, 16'h0001, 0, 2'h3, 16'ha5ff}, '{0, 16'hffff, 0, 2'h3, 16'hab34},
    '{0, 16'h0001, 0, 2'h2, 16'ha500}, '{0, 16'hffff, 0, 2'h1, 16'h0034}};
  always #10 clk_i = ~clk_i;
  asr_host #(.POWER_WAIT(4)) dut (.clk_i, .reset_n_i, .req_i, .we_i, .addr_i, .wdata_i, .be_i,
    .retain_i, .ready_o, .done_o, .rdata_o, .mem_addr_o(ma), .chip_select_n_o(cs),
    .output_enable_n_o(oe), .write_strobe_n_o(we), .low_byte_select_n_o(lb),
    .high_byte_select_n_o(hb), .data_lines_i(dli), .data_lines_o(dlo), .data_lines_oe_o(doe));
  asr_sram_model u_mem (.cs_n_i(cs), .oe_n_i(oe), .we_n_i(we), .bs_n_i({hb, lb}), .addr_i(ma),
    .host_d_i(dlo), .host_oe_i(doe), .dq_o(dli));
  task report_and_stop;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  // Bounded wait on ready (0) or done (1)
  task wt(input bit sel);
    for (int i = 0; i < 100 && (sel ? done_o : ready_o) !== 1'b1; i++) @(negedge clk_i);
    if ((sel ? done_o : ready_o) !== 1'b1)
    begin
      chk("timeout", 0, 1);
      report_and_stop;
    end
  endtask
  task op(input bit w, input logic [15:0] a, input logic [15:0] d, input logic [1:0] b);
    wt(0);
    we_i = w;
    addr_i = a;
    wdata_i = d;
    be_i = b;
    req_i = 1;
    @(negedge clk_i);
    req_i = 0;
    wt(1);
  endtask
  initial
  begin
    repeat (3) @(negedge clk_i);
    chk("cs in reset", cs, 1);
    reset_n_i = 1;
    foreach (rows[i])
    begin
      op(rows[i].w, rows[i].a, rows[i].d, rows[i].b);
      if (!rows[i].w)
        chk("rdata", rdata_o & {{8{rows[i].b[1]}}, {8{rows[i].b[0]}}}, rows[i].e);
    end
    be_i = 0;
    req_i = 1;
    @(negedge clk_i);
    req_i = 0;
    repeat (3) @(negedge clk_i);
    chk("empty req", {cs, ready_o}, 3);
    retain_i = 1;
    @(negedge clk_i);
    we_i = 0;
    addr_i = 16'h0001;
    be_i = 2'h3;
    req_i = 1;
    repeat (4) @(negedge clk_i);
    chk("retain pins", {cs, ready_o}, 16'h0002);
    req_i = 0;
    retain_i = 0;
    @(negedge clk_i);
    chk("recovering", ready_o, 0);
    op(0, 16'h0001, 0, 2'h3);
    chk("retained", rdata_o, 16'ha5ff);
    reset_n_i = 0;
    @(negedge clk_i);
    chk("reset pins", {cs, oe, we, lb, hb, ready_o}, 16'h003e);
    reset_n_i = 1;
    op(0, 16'hffff, 0, 2'h3);
    chk("after reset", rdata_o, 16'hab34);
    report_and_stop;
  end
endmodule
